// file: core/pcb_cfg.svh
/*
  constants for the pad configuration and boot strap block: strap settle count,
  strap levels, gpio pad positions and the slow crystal detect timing.
  assumes inclusion by bare name from the design files only.
*/
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH

// strap active levels
`define PCB_TEST_STRAP_ACTIVE    1'b0
`define PCB_LOADER_STRAP_ACTIVE  1'b1

// enabled edges after reset release until the synchroniser holds the strap pins
`define PCB_STRAP_SETTLE         2'h2

// gpio pad positions of the alternate functions
`define PCB_GPIO_COUNT           15
`define PCB_PAD_TWI_CLK          0
`define PCB_PAD_TWI_DATA         1
`define PCB_PAD_SPI_MOSI         2
`define PCB_PAD_SPI_MISO         5
`define PCB_PAD_SPI_SCK          8

// slow crystal detect: window length and edges needed
`define PCB_CLK_HZ               50000000
`define PCB_DETECT_WINDOW_US     2000
`define PCB_DETECT_CYCLES        ((`PCB_CLK_HZ / 1000000) * `PCB_DETECT_WINDOW_US)
`define PCB_DETECT_MIN_EDGES     16

`endif

// file: core/pcb_pkg.sv
/*
  types for the pad configuration and boot strap block.
  assumes nothing beyond a systemverilog compiler.
*/
package pcb_pkg;

  // electrical type of a pad
  typedef enum logic [1:0] {
    PAD_INPUT_DISCONNECTED = 2'b00,
    PAD_INPUT_PULLDOWN     = 2'b01,
    PAD_INPUT_FLOATING     = 2'b10,
    PAD_OUTPUT_PUSH_PULL   = 2'b11
  } pcb_pad_type;

  // start mode chosen by the straps
  typedef enum logic [1:0] {
    MODE_FIRMWARE          = 2'b00,
    MODE_BOOTLOADER        = 2'b01,
    MODE_VENDOR_TEST       = 2'b10,
    MODE_DIRECT_TEST       = 2'b11
  } pcb_mode_type;

  // boot sequencer states
  typedef enum logic [1:0] {
    BOOT_SAMPLE            = 2'b00,
    BOOT_DETECT            = 2'b01,
    BOOT_RUN               = 2'b10
  } pcb_boot_type;

endpackage : pcb_pkg

// file: core/pcb_sync.sv
/*
  two flip-flop synchroniser for a bus of pad inputs.
  assumes one clock, asynchronous active low reset and a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none

module pcb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_one;

  // first stage is read by the second stage only
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_one <= '0;
      sync_o    <= '0;
    end else if (clk_en_i) begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end

endmodule // pcb_sync

`default_nettype wire

// file: core/pcb_pad_config_and_boot_strap.sv
/*
  pad configuration and boot strap logic: pad types of the flow-permit and
  wake pads, start mode from two straps, gpio alternate function routing and
  slow crystal detection at boot.
  assumes the pad ring turns the type codes into pull and drive controls,
  and that the pad inputs arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg.svh"

// Operation
// RULE_01 - with the low-power protocol off the flow-permit pad is an input with pull-down.
// RULE_02 - with the protocol on the flow-permit pad loses its pull-down and floats.
// RULE_03 - the wake-request input pad is disconnected with the protocol off and floating with it on.
// RULE_04 - the wake-request output pad is a disconnected input with the protocol off and push-pull with it on.
// RULE_05 - the three pad types follow every change of the protocol enable.
// RULE_06 - the host drives every floating input pad to a defined level.
// RULE_07 - with the protocol on and the link down the host holds flow-permit high.
// RULE_08 - the test strap is active when low.
// RULE_09 - the loader strap is active when high.
// RULE_10 - test only gives vendor test, both give direct test, loader only gives bootloader, none gives firmware.
// RULE_11 - both test modes enable the four serial pads for the test equipment.
// RULE_12 - master-out goes to pad 2, master-in to pad 5 and serial clock to pad 8.
// RULE_13 - two-wire data goes to pad 1 and two-wire clock to pad 0 when in use.
// RULE_14 - at boot the slow crystal presence is detected and the clock source follows it.
// RULE_15 - the straps are sampled once after reset release and the mode is held until the next reset.
module pcb_pad_config_and_boot_strap #(
  parameter int GPIO_COUNT    = `PCB_GPIO_COUNT,
  parameter int DETECT_CYCLES = `PCB_DETECT_CYCLES,
  parameter int MIN_EDGES     = `PCB_DETECT_MIN_EDGES
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     low_power_link_protocol_i,
  input  wire logic                     test_strap_n_i,
  input  wire logic                     loader_strap_i,
  input  wire logic                     slow_xtal_in_i,
  input  wire logic                     twi_enable_i,
  input  wire logic                     spi_enable_i,
  input  wire logic                     spi_mosi_i,
  input  wire logic                     spi_sck_i,
  input  wire logic                     spi_sck_oe_i,
  input  wire logic                     twi_scl_oe_i,
  input  wire logic                     twi_sda_oe_i,
  input  wire logic [GPIO_COUNT-1:0]    gpio_out_i,
  input  wire logic [GPIO_COUNT-1:0]    gpio_oe_i,
  input  wire logic [GPIO_COUNT-1:0]    gpio_pad_i,
  output logic      [GPIO_COUNT-1:0]    gpio_pad_o,
  output logic      [GPIO_COUNT-1:0]    gpio_pad_oe_o,
  output logic      [GPIO_COUNT-1:0]    gpio_sync_o,
  output logic                          spi_miso_o,
  output logic                          twi_scl_o,
  output logic                          twi_sda_o,
  output pcb_pkg::pcb_pad_type          flow_permit_pad_type_o,
  output pcb_pkg::pcb_pad_type          wake_request_in_n_pad_type_o,
  output pcb_pkg::pcb_pad_type          wake_request_out_n_pad_type_o,
  output pcb_pkg::pcb_mode_type         start_mode_o,
  output logic                          serial_test_access_o,
  output logic                          slow_xtal_present_o,
  output logic                          boot_done_o
);

  localparam int CNT_W  = $clog2(DETECT_CYCLES + 1);
  localparam int EDGE_W = $clog2(MIN_EDGES + 1);

  // synchronised copies of the asynchronous pad inputs
  logic [GPIO_COUNT+3:0] pad_sync;
  logic                  lplp;
  logic                  test_strap_n;
  logic                  loader_strap;
  logic                  xtal_in;
  logic [GPIO_COUNT-1:0] gpio_in;

  pcb_sync #(
    .WIDTH (GPIO_COUNT + 4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({gpio_pad_i, slow_xtal_in_i, loader_strap_i, test_strap_n_i, low_power_link_protocol_i}),
    .sync_o    (pad_sync)
  );

  assign lplp         = pad_sync[0];
  assign test_strap_n = pad_sync[1];
  assign loader_strap = pad_sync[2];
  assign xtal_in      = pad_sync[3];
  assign gpio_in      = pad_sync[GPIO_COUNT+3:4];

  // strap decode
  function automatic pcb_pkg::pcb_mode_type decode_mode(input logic test_n, input logic loader);
    logic test_on;
    logic load_on;
    test_on = (test_n == `PCB_TEST_STRAP_ACTIVE);   // [RULE_08]
    load_on = (loader == `PCB_LOADER_STRAP_ACTIVE); // [RULE_09]
    // [RULE_10]
    if (test_on && load_on)
      decode_mode = pcb_pkg::MODE_DIRECT_TEST;
    else if (test_on)
      decode_mode = pcb_pkg::MODE_VENDOR_TEST;
    else if (load_on)
      decode_mode = pcb_pkg::MODE_BOOTLOADER;
    else
      decode_mode = pcb_pkg::MODE_FIRMWARE;
  endfunction

  // pad type selection from the protocol enable
  pcb_pkg::pcb_pad_type next_flow_type;
  pcb_pkg::pcb_pad_type next_wake_in_type;
  pcb_pkg::pcb_pad_type next_wake_out_type;

  assign next_flow_type     = lplp ? pcb_pkg::PAD_INPUT_FLOATING
                                   : pcb_pkg::PAD_INPUT_PULLDOWN;       // [RULE_01] [RULE_02]
  assign next_wake_in_type  = lplp ? pcb_pkg::PAD_INPUT_FLOATING
                                   : pcb_pkg::PAD_INPUT_DISCONNECTED;   // [RULE_03]
  assign next_wake_out_type = lplp ? pcb_pkg::PAD_OUTPUT_PUSH_PULL
                                   : pcb_pkg::PAD_INPUT_DISCONNECTED;   // [RULE_04]

  // pad types register every enabled cycle so they track the enable
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flow_permit_pad_type_o        <= pcb_pkg::PAD_INPUT_DISCONNECTED;
      wake_request_in_n_pad_type_o  <= pcb_pkg::PAD_INPUT_DISCONNECTED;
      wake_request_out_n_pad_type_o <= pcb_pkg::PAD_INPUT_DISCONNECTED;
    end else if (clk_en_i) begin
      flow_permit_pad_type_o        <= next_flow_type;     // [RULE_05]
      wake_request_in_n_pad_type_o  <= next_wake_in_type;  // [RULE_05]
      wake_request_out_n_pad_type_o <= next_wake_out_type; // [RULE_05]
    end
  end

  // boot sequencer: sample straps, then count crystal edges in a window
  pcb_pkg::pcb_boot_type state;
  pcb_pkg::pcb_boot_type next_state;
  logic [1:0]            settle_cnt;
  logic                  straps_settled;
  logic                  strap_capture;
  logic [CNT_W-1:0]      win_cnt;
  logic [EDGE_W-1:0]     edge_cnt;
  logic                  xtal_prev;
  logic                  xtal_edge;
  logic                  window_end;
  logic                  edges_full;

  // straps are read only once the synchroniser holds the pin levels
  assign straps_settled = (settle_cnt == `PCB_STRAP_SETTLE);
  assign strap_capture  = (state == pcb_pkg::BOOT_SAMPLE) && straps_settled;
  assign xtal_edge  = xtal_in && !xtal_prev;
  assign window_end = (win_cnt == CNT_W'(DETECT_CYCLES - 1));
  assign edges_full = (edge_cnt == EDGE_W'(MIN_EDGES));

  always_comb begin
    next_state = state;
    unique case (state)
      pcb_pkg::BOOT_SAMPLE: if (straps_settled) next_state = pcb_pkg::BOOT_DETECT;
      pcb_pkg::BOOT_DETECT: if (window_end || edges_full) next_state = pcb_pkg::BOOT_RUN;
      pcb_pkg::BOOT_RUN:    next_state = pcb_pkg::BOOT_RUN;
      default:              next_state = pcb_pkg::BOOT_SAMPLE;
    endcase
  end

  // state and strap capture; reading the synchroniser's reset value would fake an active test strap
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state        <= pcb_pkg::BOOT_SAMPLE;
      settle_cnt   <= 2'h0;
      start_mode_o <= pcb_pkg::MODE_FIRMWARE;
    end else if (clk_en_i) begin
      state <= next_state;
      if ((state == pcb_pkg::BOOT_SAMPLE) && !straps_settled)
        settle_cnt <= settle_cnt + 2'h1;
      if (strap_capture)
        start_mode_o <= decode_mode(test_strap_n, loader_strap); // [RULE_15]
    end
  end

  // crystal detection window
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt             <= '0;
      edge_cnt            <= '0;
      xtal_prev           <= 1'b0;
      slow_xtal_present_o <= 1'b0;
      boot_done_o         <= 1'b0;
    end else if (clk_en_i) begin
      xtal_prev <= xtal_in;
      if (state == pcb_pkg::BOOT_DETECT) begin
        win_cnt <= win_cnt + CNT_W'(1);
        if (xtal_edge && !edges_full)
          edge_cnt <= edge_cnt + EDGE_W'(1);
        if (window_end || edges_full) begin
          slow_xtal_present_o <= edges_full; // [RULE_14]
          boot_done_o         <= 1'b1;
        end
      end
    end
  end

  // serial test access in both test modes
  logic next_test_access;
  assign next_test_access = (start_mode_o == pcb_pkg::MODE_VENDOR_TEST) ||
                            (start_mode_o == pcb_pkg::MODE_DIRECT_TEST); // [RULE_11]

  // gpio alternate function muxing
  logic [GPIO_COUNT-1:0] next_pad_out;
  logic [GPIO_COUNT-1:0] next_pad_oe;

  always_comb begin
    next_pad_out = gpio_out_i;
    next_pad_oe  = gpio_oe_i;
    if (spi_enable_i) begin
      next_pad_out[`PCB_PAD_SPI_MOSI] = spi_mosi_i; // [RULE_12]
      next_pad_oe[`PCB_PAD_SPI_MOSI]  = 1'b1;
      next_pad_out[`PCB_PAD_SPI_MISO] = 1'b0;       // [RULE_12]
      next_pad_oe[`PCB_PAD_SPI_MISO]  = 1'b0;
      next_pad_out[`PCB_PAD_SPI_SCK]  = spi_sck_i;  // [RULE_12]
      next_pad_oe[`PCB_PAD_SPI_SCK]   = spi_sck_oe_i;
    end
    if (twi_enable_i) begin
      // open drain: drive low only while enabled
      next_pad_out[`PCB_PAD_TWI_CLK]  = 1'b0;         // [RULE_13]
      next_pad_oe[`PCB_PAD_TWI_CLK]   = twi_scl_oe_i;
      next_pad_out[`PCB_PAD_TWI_DATA] = 1'b0;         // [RULE_13]
      next_pad_oe[`PCB_PAD_TWI_DATA]  = twi_sda_oe_i;
    end
  end

  // registered pad drive and alternate inputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpio_pad_o           <= '0;
      gpio_pad_oe_o        <= '0;
      gpio_sync_o          <= '0;
      spi_miso_o           <= 1'b0;
      twi_scl_o            <= 1'b1;
      twi_sda_o            <= 1'b1;
      serial_test_access_o <= 1'b0;
    end else if (clk_en_i) begin
      gpio_pad_o           <= next_pad_out;
      gpio_pad_oe_o        <= next_pad_oe;
      gpio_sync_o          <= gpio_in;
      spi_miso_o           <= spi_enable_i ? gpio_in[`PCB_PAD_SPI_MISO] : 1'b0; // [RULE_12]
      twi_scl_o            <= twi_enable_i ? gpio_in[`PCB_PAD_TWI_CLK] : 1'b1;  // [RULE_13]
      twi_sda_o            <= twi_enable_i ? gpio_in[`PCB_PAD_TWI_DATA] : 1'b1; // [RULE_13]
      serial_test_access_o <= next_test_access;
    end
  end

  // assertions
  a_flow_pulldown_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_01]
    clk_en_i && !lplp |=> flow_permit_pad_type_o == pcb_pkg::PAD_INPUT_PULLDOWN)
    else $error("flow permit pad lacks pull-down with protocol off");

  a_flow_float_on: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_02]
    clk_en_i && lplp |=> flow_permit_pad_type_o == pcb_pkg::PAD_INPUT_FLOATING)
    else $error("flow permit pad not floating with protocol on");

  a_wake_in_type: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_03]
    clk_en_i |=> wake_request_in_n_pad_type_o ==
      ($past(lplp) ? pcb_pkg::PAD_INPUT_FLOATING : pcb_pkg::PAD_INPUT_DISCONNECTED))
    else $error("wake request input pad type wrong");

  a_wake_out_type: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_04]
    clk_en_i |=> (wake_request_out_n_pad_type_o == pcb_pkg::PAD_OUTPUT_PUSH_PULL) == $past(lplp))
    else $error("wake request output pad type wrong");

  sequence s_enable_change;
    clk_en_i && (lplp != $past(lplp));
  endsequence
  a_type_follows: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_05]
    s_enable_change |=> $changed(flow_permit_pad_type_o))
    else $error("pad type did not follow protocol change");

  a_mode_direct: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_10]
    clk_en_i && strap_capture && !test_strap_n && loader_strap
      |=> start_mode_o == pcb_pkg::MODE_DIRECT_TEST)
    else $error("both straps active did not select direct test");

  a_mode_vendor: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_08]
    clk_en_i && strap_capture && !test_strap_n && !loader_strap
      |=> start_mode_o == pcb_pkg::MODE_VENDOR_TEST)
    else $error("low test strap did not select vendor test");

  a_mode_loader: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_09]
    clk_en_i && strap_capture && test_strap_n && loader_strap
      |=> start_mode_o == pcb_pkg::MODE_BOOTLOADER)
    else $error("high loader strap did not select bootloader");

  a_mode_firmware: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_10]
    clk_en_i && strap_capture && test_strap_n && !loader_strap
      |=> start_mode_o == pcb_pkg::MODE_FIRMWARE)
    else $error("no active strap did not select firmware");

  a_mode_held: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_15]
    state != pcb_pkg::BOOT_SAMPLE |=> $stable(start_mode_o))
    else $error("start mode changed after sampling");

  a_test_access: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_11]
    clk_en_i && start_mode_o[1] |=> serial_test_access_o)
    else $error("test mode without serial access");

  a_spi_mosi_route: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_12]
    clk_en_i && spi_enable_i |=> gpio_pad_o[`PCB_PAD_SPI_MOSI] == $past(spi_mosi_i)
      && gpio_pad_oe_o[`PCB_PAD_SPI_MOSI])
    else $error("spi master out not on pad 2");

  a_twi_clk_route: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_13]
    clk_en_i && twi_enable_i |=> gpio_pad_oe_o[`PCB_PAD_TWI_CLK] == $past(twi_scl_oe_i)
      && !gpio_pad_o[`PCB_PAD_TWI_CLK])
    else $error("two-wire clock not on pad 0");

  a_xtal_found: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RULE_14]
    clk_en_i && state == pcb_pkg::BOOT_DETECT && edges_full |=> slow_xtal_present_o && boot_done_o)
    else $error("crystal edges seen but not reported");

endmodule // pcb_pad_config_and_boot_strap

`default_nettype wire

// file: test/pcb_host_model.sv
/*
  host controller and strap fixture model for the pad configuration block:
  strap levels, a scaled slow crystal, the flow-permit line and pad levels.
  assumes the bench gives it the wanted strap states, link state and host levels.
*/
`timescale 1ns/1ps
`default_nettype none

module pcb_host_model #(
  parameter int XTAL_HALF_NS = 70
) (
  input  wire logic        test_active_i,
  input  wire logic        loader_active_i,
  input  wire logic        xtal_fitted_i,
  input  wire logic        protocol_on_i,
  input  wire logic        link_up_i,
  input  wire logic [14:0] host_level_i,
  input  wire logic [14:0] dut_pad_i,
  input  wire logic [14:0] dut_oe_i,
  output logic             test_strap_n_o,
  output logic             loader_strap_o,
  output logic             slow_xtal_o,
  output logic             flow_permit_n_o,
  output logic      [14:0] pad_o
);
  logic xtal_osc;

  // strap fixture: test strap tied to ground and loader strap to supply when active
  assign test_strap_n_o = ~test_active_i;
  assign loader_strap_o = loader_active_i;

  // flow-permit kept at the inactive high level while the protocol is on and the link is down
  assign flow_permit_n_o = (protocol_on_i && !link_up_i) ? 1'b1 : 1'b0;

  // scaled slow crystal, free running but stands at 0 when none is fitted
  initial xtal_osc = 1'b0;
  always #(XTAL_HALF_NS) xtal_osc = ~xtal_osc;
  assign slow_xtal_o = xtal_fitted_i & xtal_osc;

  // no pad floats: device drive wins, otherwise the host drives a level
  assign pad_o = (dut_oe_i & dut_pad_i) | (~dut_oe_i & host_level_i);
endmodule // pcb_host_model

`default_nettype wire

// file: test/pcb_pad_config_and_boot_strap_bench.sv
/*
  self-checking bench for the pad configuration and boot strap block.
  assumes the host model beside it and shortened crystal detect counts.
*/
`timescale 1ns/1ps
`default_nettype none

module pcb_pad_config_and_boot_strap_bench;
  localparam int DET = 64;
  localparam int EDG = 4;
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  lpl_on = 1'b0;
  logic                  twi_en = 1'b0;
  logic                  spi_en = 1'b0;
  logic                  mosi = 1'b0;
  logic                  sck = 1'b0;
  logic                  sck_oe = 1'b0;
  logic                  clk_en = 1'b1;
  logic                  scl_oe = 1'b0;
  logic                  sda_oe = 1'b0;
  logic                  test_act = 1'b0;
  logic                  loader_act = 1'b0;
  logic                  xtal_fit = 1'b0;
  logic [14:0]           gpio_out = 15'h0000;
  logic [14:0]           gpio_oe = 15'h0000;
  logic [14:0]           host_level = 15'h0003;
  logic [14:0]           pad_lvl, pad_o, pad_oe, gsync;
  logic                  test_strap_n, loader_strap, slow_xtal, miso, scl, sda, test_acc, xtal_ok, boot_done;
  pcb_pkg::pcb_pad_type  fp_type, wi_type, wo_type;
  pcb_pkg::pcb_mode_type mode;
  int                    mismatches = 0;
  int                    checks_done = 0;

  // 50 mhz clock
  always #10 sys_clk = ~sys_clk;

  pcb_pad_config_and_boot_strap #(.DETECT_CYCLES(DET), .MIN_EDGES(EDG)) i_dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .low_power_link_protocol_i(lpl_on),
    .test_strap_n_i(test_strap_n), .loader_strap_i(loader_strap), .slow_xtal_in_i(slow_xtal),
    .twi_enable_i(twi_en), .spi_enable_i(spi_en), .spi_mosi_i(mosi), .spi_sck_i(sck),
    .spi_sck_oe_i(sck_oe), .twi_scl_oe_i(scl_oe), .twi_sda_oe_i(sda_oe), .gpio_out_i(gpio_out),
    .gpio_oe_i(gpio_oe), .gpio_pad_i(pad_lvl), .gpio_pad_o(pad_o), .gpio_pad_oe_o(pad_oe),
    .gpio_sync_o(gsync), .spi_miso_o(miso), .twi_scl_o(scl), .twi_sda_o(sda),
    .flow_permit_pad_type_o(fp_type), .wake_request_in_n_pad_type_o(wi_type),
    .wake_request_out_n_pad_type_o(wo_type), .start_mode_o(mode), .serial_test_access_o(test_acc),
    .slow_xtal_present_o(xtal_ok), .boot_done_o(boot_done));

  pcb_host_model i_host (
    .test_active_i(test_act), .loader_active_i(loader_act), .xtal_fitted_i(xtal_fit),
    .protocol_on_i(lpl_on), .link_up_i(1'b0), .host_level_i(host_level), .dut_pad_i(pad_o),
    .dut_oe_i(pad_oe), .test_strap_n_o(test_strap_n), .loader_strap_o(loader_strap),
    .slow_xtal_o(slow_xtal), .flow_permit_n_o(), .pad_o(pad_lvl));

  // compare and count
  task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // wait n edges, then let the edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // start mode expected from the strap states
  function automatic logic [1:0] exp_mode(input logic t, input logic l);
    if (t) return l ? pcb_pkg::MODE_DIRECT_TEST : pcb_pkg::MODE_VENDOR_TEST;
    return l ? pcb_pkg::MODE_BOOTLOADER : pcb_pkg::MODE_FIRMWARE;
  endfunction

  // reset with given straps and crystal, wait for boot, check outcome
  task automatic boot(input logic t, input logic l, input logic x);
    int n;
    @(posedge sys_clk);
    test_act <= t;
    loader_act <= l;
    xtal_fit <= x;
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    n = 0;
    while (boot_done !== 1'b1 && n < DET + 40) begin
      @(posedge sys_clk);
      n++;
    end
    tick(1);
    check("boot_done", boot_done, 15'h0001);
    check("slow_xtal_present", xtal_ok, x);
    check("start_mode", mode, exp_mode(t, l));
    check("serial_test_access", test_acc, t);
    @(posedge sys_clk);
    test_act <= ~t;
    loader_act <= ~l;
    tick(5);
    check("start_mode held", mode, exp_mode(t, l));
  endtask

  // toggle the protocol enable and follow the three pad types
  task automatic set_protocol(input logic on);
    @(posedge sys_clk);
    lpl_on <= on;
    tick(2);
    check("flow_permit type early", fp_type, on ? pcb_pkg::PAD_INPUT_PULLDOWN : pcb_pkg::PAD_INPUT_FLOATING);
    tick(1);
    check("flow_permit type", fp_type, on ? pcb_pkg::PAD_INPUT_FLOATING : pcb_pkg::PAD_INPUT_PULLDOWN);
    check("wake_in type", wi_type, on ? pcb_pkg::PAD_INPUT_FLOATING : pcb_pkg::PAD_INPUT_DISCONNECTED);
    check("wake_out type", wo_type, on ? pcb_pkg::PAD_OUTPUT_PUSH_PULL : pcb_pkg::PAD_INPUT_DISCONNECTED);
  endtask

  // main sequence: straps, pad types, alternate functions
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(i[1], i[0], i[1] ^ i[0]);
    end
    for (int k = 0; k < 4; k++) begin
      set_protocol(!k[0]);
    end
    // clock enable low freezes the pad types until it returns
    @(posedge sys_clk);
    clk_en <= 1'b0;
    lpl_on <= 1'b1;
    tick(5);
    check("flow_permit type frozen", fp_type, pcb_pkg::PAD_INPUT_PULLDOWN);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    tick(3);
    check("flow_permit type thawed", fp_type, pcb_pkg::PAD_INPUT_FLOATING);
    check("wake_out type thawed", wo_type, pcb_pkg::PAD_OUTPUT_PUSH_PULL);
    @(posedge sys_clk);
    gpio_out <= 15'h0004;
    gpio_oe <= 15'h0004;
    tick(1);
    check("plain gpio pad 2", {pad_oe[2], pad_o[2]}, 15'h0003);
    @(posedge sys_clk);
    spi_en <= 1'b1;
    sck <= 1'b1;
    sck_oe <= 1'b1;
    tick(1);
    check("mosi pad 2", {pad_oe[2], pad_o[2]}, 15'h0002);
    check("sck pad 8", {pad_oe[8], pad_o[8]}, 15'h0003);
    @(posedge sys_clk);
    mosi <= 1'b1;
    host_level[5] <= 1'b1;
    tick(4);
    check("mosi pad 2 high", pad_o[2], 15'h0001);
    check("miso from pad 5", miso, 15'h0001);
    @(posedge sys_clk);
    host_level[5] <= 1'b0;
    twi_en <= 1'b1;
    scl_oe <= 1'b1;
    host_level[1] <= 1'b0;
    tick(1);
    check("twi clock pad 0", {pad_oe[0], pad_o[0]}, 15'h0002);
    check("twi data pad 1 released", pad_oe[1], 15'h0000);
    tick(3);
    check("miso low", miso, 15'h0000);
    check("twi data in", sda, 15'h0000);
    check("twi clock in", scl, 15'h0000);
    @(posedge sys_clk);
    scl_oe <= 1'b0;
    sda_oe <= 1'b1;
    host_level[1] <= 1'b1;
    tick(4);
    check("twi data pad 1 driven", {pad_oe[1], pad_o[1]}, 15'h0002);
    check("twi clock released", scl, 15'h0001);
    check("gpio sync levels", gsync, 15'h0105);
    finish_test();
  end

  // watchdog well beyond the expected run of about three hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
endmodule // pcb_pad_config_and_boot_strap_bench

`default_nettype wire
